// ===== core/pcdc_level.sv
// brightness level counter driven by qualified pulse events
module pcdc_level
   import pcdc_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   pcdc_pulse_if.level              ev,
   output logic [LEVEL_W-1:0]       level_reg,
   output logic                     on_reg
);
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         level_reg <= LEVEL_FULL; // R3
      end else if (ev.wake) begin
         level_reg <= LEVEL_FULL;
      end else if (ev.step) begin
         // 4-bit wrap: lowest step goes back to full
         level_reg <= level_reg - 4'h1; // R1 R5 R6 R10
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         on_reg <= 1'b1; // R3
      end else if (ev.shutdown) begin
         on_reg <= 1'b0; // R2
      end else if (ev.wake) begin
         on_reg <= 1'b1;
      end
   end
endmodule : pcdc_level

// ===== core/pcdc_pkg.sv
// package: timing constants, level encodings and states of the pulse count dimming control
package pcdc_pkg;
   localparam int unsigned CLK_HZ              = 40000000;
   // times in microseconds
   localparam int unsigned DIMMING_LOW_MIN_US  = 100;
   localparam int unsigned DIMMING_LOW_MAX_US  = 300;
   localparam int unsigned DIMMING_HIGH_MIN_US = 100;
   localparam int unsigned SHUTDOWN_LOW_US     = 1000;
   // least times round up, longest times round down
   localparam int unsigned DIMMING_LOW_MIN_CYC =
      (DIMMING_LOW_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int unsigned DIMMING_LOW_MAX_CYC =
      (DIMMING_LOW_MAX_US * (CLK_HZ / 1000)) / 1000;
   localparam int unsigned DIMMING_HIGH_CYC    =
      (DIMMING_HIGH_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int unsigned SHUTDOWN_LOW_CYC    =
      (SHUTDOWN_LOW_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int unsigned CNT_W               = 16;
   localparam int unsigned LEVEL_W             = 4;
   localparam logic [3:0]  LEVEL_FULL          = 4'hF;
   localparam logic [3:0]  LEVEL_LOWEST        = 4'h0;

   typedef enum logic [1:0] {
      PCDC_ST_HIGH    = 2'b00,
      PCDC_ST_LOW     = 2'b01,
      PCDC_ST_QUALIFY = 2'b10,
      PCDC_ST_OFF     = 2'b11
   } pcdc_state_type;
endpackage : pcdc_pkg

// ===== core/pcdc_pulse_if.sv
// interface: qualified dimming step and shutdown events from the timer to the level counter
interface pcdc_pulse_if;
   logic step;
   logic shutdown;
   logic wake;
   modport timer (output step, output shutdown, output wake);
   modport level (input step, input shutdown, input wake);
endinterface : pcdc_pulse_if

// ===== core/pcdc_top.sv
// pulse count dimming control: times enable pulses and steps the sink current level
// Overview of operation
// R1: low within window then long enough high lowers current one sixteenth.
// R2: enable low beyond shutdown delay turns the device off.
// R3: at power-on the level is full scale.
// R4: full scale holds until the first qualifying pulse.
// R5: fifteen qualifying pulses from full reach the one sixteenth step.
// R6: one more pulse at the lowest step wraps to full scale.
// R7: host holds dimming low between minimum and maximum low time.
// R8: host keeps enable high at least minimum high time between pulses.
// R9: low at least the shutdown delay is a shutdown request.
// R10: durations counted in clock cycles; four-bit level gives sixteen steps.
module pcdc_top
   import pcdc_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   input  wire logic                enable_in,
   output logic [LEVEL_W-1:0]       current_level,
   output logic                     sink_on
);
   localparam logic [CNT_W-1:0] LO_MIN = CNT_W'(DIMMING_LOW_MIN_CYC);
   localparam logic [CNT_W-1:0] LO_MAX = CNT_W'(DIMMING_LOW_MAX_CYC);
   localparam logic [CNT_W-1:0] HI_MIN = CNT_W'(DIMMING_HIGH_CYC);
   localparam logic [CNT_W-1:0] SD_CYC = CNT_W'(SHUTDOWN_LOW_CYC);

   pcdc_state_type   state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic             en_reg;
   pcdc_pulse_if     ev ();

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         en_reg <= 1'b1;
      end else begin
         en_reg <= enable_in;
      end
   end

   wire logic fall = en_reg & ~enable_in;
   wire logic rise = ~en_reg & enable_in;

   // duration counter restarts at every edge and saturates
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cnt_reg <= '0;
      end else if (fall || rise) begin
         cnt_reg <= CNT_W'(1); // R10
      end else if (cnt_reg != {CNT_W{1'b1}}) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= PCDC_ST_HIGH;
      end else begin
         unique case (state_reg)
            PCDC_ST_HIGH: begin
               if (fall) begin
                  state_reg <= PCDC_ST_LOW;
               end
            end
            PCDC_ST_LOW: begin
               if (!enable_in && cnt_reg >= SD_CYC - CNT_W'(1)) begin
                  state_reg <= PCDC_ST_OFF; // R2 R9
               end else if (rise) begin
                  if (cnt_reg >= LO_MIN && cnt_reg <= LO_MAX) begin
                     state_reg <= PCDC_ST_QUALIFY; // R7
                  end else begin
                     state_reg <= PCDC_ST_HIGH;
                  end
               end
            end
            PCDC_ST_QUALIFY: begin
               if (fall) begin
                  state_reg <= PCDC_ST_LOW; // R8
               end else if (cnt_reg >= HI_MIN) begin
                  state_reg <= PCDC_ST_HIGH;
               end
            end
            PCDC_ST_OFF: begin
               if (rise) begin
                  state_reg <= PCDC_ST_HIGH;
               end
            end
         endcase
      end
   end

   // step fires once the high phase after a valid low lasts the minimum high time
   assign ev.step     = (state_reg == PCDC_ST_QUALIFY) && !fall && (cnt_reg >= HI_MIN); // R1 R4
   assign ev.shutdown = (state_reg == PCDC_ST_LOW) && !enable_in
                        && (cnt_reg >= SD_CYC - CNT_W'(1)); // R2
   assign ev.wake     = (state_reg == PCDC_ST_OFF) && rise;

   pcdc_level u_level (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .ev        (ev.level),
      .level_reg (current_level),
      .on_reg    (sink_on)
   );

   AST_STEP_DECREMENTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.step && !ev.wake |=> current_level == $past(current_level) - 4'h1) // R1
      else $error("level did not drop one step");
   AST_WRAP_TO_FULL: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.step && current_level == LEVEL_LOWEST |=> current_level == LEVEL_FULL) // R6
      else $error("lowest level did not wrap to full");
   AST_HOLD_NO_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !ev.step && !ev.wake |=> $stable(current_level)) // R4
      else $error("level moved without a pulse");
   AST_SHUTDOWN_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.shutdown |=> !sink_on) // R2
      else $error("shutdown did not turn sink off");
   AST_NO_STEP_WHEN_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == PCDC_ST_OFF |-> !ev.step) // R9
      else $error("step while off");
   AST_RESET_FULL: assert property (@(posedge clk_sys)
      sys_rst |=> current_level == LEVEL_FULL && sink_on) // R3
      else $error("reset did not give full scale");
   AST_STEP_NEEDS_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.step |-> enable_in && cnt_reg >= HI_MIN) // R1
      else $error("step without minimum high time");
   AST_SINGLE_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.step |=> !ev.step) // R5
      else $error("more than one step per pulse");

   // checker side: own run-length counts of the enable level, kept apart from cnt_reg
   // so that a slip in the duration counter cannot hide itself
   logic [CNT_W-1:0] low_run_reg;
   logic [CNT_W-1:0] high_run_reg;
   logic             step_seen_reg;

   // consecutive low samples before this edge
   always_ff @(posedge clk_sys) begin
      if (sys_rst || enable_in) begin
         low_run_reg <= '0;
      end else if (low_run_reg != {CNT_W{1'b1}}) begin
         low_run_reg <= low_run_reg + CNT_W'(1);
      end
   end

   // consecutive high samples before this edge
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !enable_in) begin
         high_run_reg <= '0;
      end else if (high_run_reg != {CNT_W{1'b1}}) begin
         high_run_reg <= high_run_reg + CNT_W'(1);
      end
   end

   // one step per low pulse: set by a step, cleared by the next fall
   always_ff @(posedge clk_sys) begin
      if (sys_rst || fall) begin
         step_seen_reg <= 1'b0;
      end else if (ev.step) begin
         step_seen_reg <= 1'b1;
      end
   end

   // pulse qualification
   AST_VALID_LOW_QUALIFIES: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == PCDC_ST_LOW && rise && low_run_reg >= LO_MIN && low_run_reg <= LO_MAX
      |=> state_reg == PCDC_ST_QUALIFY) // R1
      else $error("valid low phase not accepted");
   AST_BAD_LOW_IGNORED: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == PCDC_ST_LOW && rise && (low_run_reg < LO_MIN || low_run_reg > LO_MAX)
      |=> state_reg == PCDC_ST_HIGH && $stable(current_level)) // R1
      else $error("low phase outside window was accepted");
   AST_FALL_ABANDONS: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == PCDC_ST_QUALIFY && fall |-> !ev.step ##1 state_reg == PCDC_ST_LOW) // R1
      else $error("early fall did not abandon the step");
   AST_STEP_AFTER_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.step |-> high_run_reg == HI_MIN) // R1
      else $error("step not at the end of the minimum high time");
   AST_ONE_STEP_PER_PULSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.step |-> !step_seen_reg) // R5
      else $error("second step within one pulse");
   AST_HIGH_STAYS_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == PCDC_ST_HIGH && !fall |=> state_reg == PCDC_ST_HIGH) // R4
      else $error("idle state left without a fall");
   AST_WRAP_ONLY_FROM_LOWEST: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $changed(current_level) && current_level == LEVEL_FULL
      |-> $past(current_level) == LEVEL_LOWEST || $past(ev.wake)) // R6
      else $error("full scale reached from a middle level");

   // shutdown and wake
   AST_SHUTDOWN_DELAY: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.shutdown |-> low_run_reg == SD_CYC - CNT_W'(1)) // R9
      else $error("shutdown before the delay ran out");
   AST_SHUTDOWN_TAKEN: assert property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == PCDC_ST_LOW && !enable_in && low_run_reg == SD_CYC - CNT_W'(1)
      |-> ev.shutdown) // R2
      else $error("long low phase did not shut down");
   AST_OFF_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !sink_on && !ev.wake |=> !sink_on) // R2
      else $error("sink turned on without a wake");
   AST_ON_HOLDS: assert property (@(posedge clk_sys) disable iff (sys_rst)
      sink_on && !ev.shutdown |=> sink_on) // R2
      else $error("sink turned off without a shutdown");
   AST_OFF_FROM_SHUTDOWN: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(sink_on) |-> $past(ev.shutdown)) // R2
      else $error("sink fell without a shutdown event");
   AST_WAKE_FULL: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ev.wake |=> sink_on && current_level == LEVEL_FULL) // R3
      else $error("wake did not restore full scale");

   COV_STEP: cover property (@(posedge clk_sys) disable iff (sys_rst) ev.step);
   COV_WRAP: cover property (@(posedge clk_sys) disable iff (sys_rst)
      ev.step && current_level == LEVEL_LOWEST);
   COV_OFF:  cover property (@(posedge clk_sys) disable iff (sys_rst) ev.shutdown);
   COV_WAKE: cover property (@(posedge clk_sys) disable iff (sys_rst) ev.wake);
   COV_ABANDON: cover property (@(posedge clk_sys) disable iff (sys_rst)
      state_reg == PCDC_ST_QUALIFY && fall);
endmodule : pcdc_top

// ===== dv/pcdc_host_model.sv
// host model: drives dimming and shutdown pulses on the enable line
module pcdc_host_model (
   input  wire logic clk_sys,
   output logic      enable_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial enable_in = 1'b1;

   // low phase then high phase in clock cycles; called and changed at falling edges
   task automatic pulse(input int unsigned low_cyc, input int unsigned high_cyc);
      enable_in = 1'b0;
      repeat (low_cyc) @(negedge clk_sys);
      enable_in = 1'b1;
      repeat (high_cyc) @(negedge clk_sys);
   endtask : pulse
endmodule : pcdc_host_model

// ===== dv/test_pulse_count_dimming_control.sv
// testbench: power-on level, dimming steps, wrap and shutdown of the dimming control
module test_pulse_count_dimming_control
   import pcdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk_sys = 1'b0;
   logic                sys_rst = 1'b1;
   logic                enable_in;
   logic [LEVEL_W-1:0]  current_level;
   logic                sink_on;
   int unsigned         n_mismatch = 0;
   int unsigned         check_count = 0;

   always #12.5 clk_sys = ~clk_sys;

   pcdc_host_model i_host (.clk_sys(clk_sys), .enable_in(enable_in));

   pcdc_top i_dut (
      .clk_sys       (clk_sys),
      .sys_rst       (sys_rst),
      .enable_in     (enable_in),
      .current_level (current_level),
      .sink_on       (sink_on)
   );

   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   task automatic test_power_on();
      check(current_level, LEVEL_FULL);
      check({3'h0, sink_on}, 4'h1);
      // too short, too long and abandoned pulses must not count as a step
      i_host.pulse(2000, 4100);
      check(current_level, LEVEL_FULL);
      i_host.pulse(13000, 4100);
      check(current_level, LEVEL_FULL);
      check({3'h0, sink_on}, 4'h1);
      // high phase too short: the next fall abandons this step
      i_host.pulse(4100, 2000);
      check(current_level, LEVEL_FULL);
      $display("test_power_on done");
   endtask : test_power_on

   task automatic test_steps();
      for (int i = 1; i <= 15; i++) begin
         i_host.pulse(4100, 4100);
         check(current_level, 4'(15 - i));
      end
      check(current_level, LEVEL_LOWEST);
      i_host.pulse(4100, 4100);
      check(current_level, LEVEL_FULL);
      $display("test_steps done");
   endtask : test_steps

   task automatic test_shutdown();
      i_host.pulse(4100, 4100);
      check(current_level, 4'hE);
      // enable rises at return, so the off state is still visible here
      i_host.pulse(40100, 0);
      check({3'h0, sink_on}, 4'h0);
      repeat (4) @(negedge clk_sys);
      check({3'h0, sink_on}, 4'h1);
      check(current_level, LEVEL_FULL);
      $display("test_shutdown done");
   endtask : test_shutdown

   initial begin
      repeat (250000) @(posedge clk_sys);
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      close_out();
   end

   initial begin
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      test_power_on();
      test_steps();
      test_shutdown();
      close_out();
   end
endmodule : test_pulse_count_dimming_control
